/* File: inc/usrc_pkg.sv */
// Shared constants for the ULPI suspend, resume and raw transmit control
// Assumes a single 100 MHz clock and a byte-wide link transmit port
package usrc_pkg;

    // Clock period in nanoseconds
    localparam int unsigned CLK_PERIOD_NS = 10;

    // Operating mode encodings
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_NODRIVE = 2'h1;
    localparam logic [1:0] MODE_CHIRP   = 2'h2;
    localparam logic [1:0] MODE_RAW     = 2'h3;

    // Speed select encodings
    localparam logic [1:0] SPEED_HIGH = 2'h0;
    localparam logic [1:0] SPEED_FULL = 2'h1;

    // Special bytes seen on the transmit port
    localparam logic [7:0] BYTE_EOP_NOSTUFF = 8'hFE;
    localparam logic [7:0] BYTE_EOP_NONE    = 8'h00;
    localparam logic [7:0] PID_SOF          = 8'hA5;

    // End-of-packet kinds handed to the serialiser
    localparam logic [1:0] EOP_NONE    = 2'h0;
    localparam logic [1:0] EOP_NORMAL  = 2'h1;
    localparam logic [1:0] EOP_NOSTUFF = 2'h2;
    localparam logic [1:0] EOP_LONG    = 2'h3;

    // ID change report time, and derived cycle count (rounded down)
    localparam int unsigned ID_REPORT_TIME_NS = 1000;
    localparam int unsigned ID_REPORT_CYC     = ID_REPORT_TIME_NS / CLK_PERIOD_NS;

    // ID pin stability filter, kept well inside the report time
    localparam int unsigned ID_FILTER_CYC = 16;

    // Transmit sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SYNC = 2'b01,
        ST_DATA = 2'b10
    } usrc_state_t;

endpackage : usrc_pkg

/* File: verification/test_usrc_top.sv */
// Self-checking bench for the transmit framing and ID reporting block
// Assumes the link model drives the transmit port on the same clock
`timescale 1ns/1ps
module test_usrc_top;
    logic       ref_clk = 1'b0;
    logic       srst = 1'b1;
    logic [1:0] op_mode = 2'h0;
    logic [1:0] speed = 2'h0;
    logic       term = 1'b0;
    logic       low_power_n = 1'b1;
    logic       pd_host = 1'b0;  // Both pull-downs, host role
    logic       id_sense_en = 1'b0;
    logic       id_pin = 1'b1;
    logic       go = 1'b0;
    logic       stall = 1'b0;
    logic [7:0] pid = 8'h00;
    logic [3:0] nbytes = 4'h0;
    logic [7:0] stop_byte = 8'h00;
    wire  [7:0] tx_data, ser_data;
    wire  [1:0] eop_kind;
    wire        tx_valid, tx_stop, tx_ready, busy, ser_valid, stuff_en, ser_sync;
    wire        eop_req, resume_k, suspended, hs_term, id_level, id_change;
    int         err_total = 0;
    int         compares = 0;
    int         cyc = 0;
    int         eop_cnt = 0;
    int         byte_cnt = 0;
    int         sync_cnt = 0;
    logic [1:0] kind_seen = 2'h0;
    logic [7:0] last_data = 8'h00;
    logic       last_stuff = 1'b1;
    logic       rk_seen = 1'b0;

    always #5 ref_clk = ~ref_clk;

    usrc_top usrc_top_inst (
        .REF_CLK_I(ref_clk), .SRST_I(srst), .OPERATING_MODE_I(op_mode),
        .SPEED_SELECT_I(speed), .TERMINATION_SELECT_I(term), .LOW_POWER_N_I(low_power_n),
        .PLUS_LINE_PULLDOWN_I(pd_host), .MINUS_LINE_PULLDOWN_I(pd_host),
        .ID_SENSE_PULLUP_I(id_sense_en), .ID_PIN_I(id_pin), .TX_DATA_I(tx_data),
        .TX_VALID_I(tx_valid), .TX_STOP_I(tx_stop), .TX_READY_O(tx_ready),
        .SER_DATA_O(ser_data), .SER_VALID_O(ser_valid), .SER_STUFF_EN_O(stuff_en),
        .SER_SYNC_O(ser_sync), .EOP_REQ_O(eop_req), .EOP_KIND_O(eop_kind),
        .RESUME_K_O(resume_k), .SUSPENDED_O(suspended), .HS_TERM_O(hs_term),
        .ID_LEVEL_O(id_level), .ID_CHANGE_O(id_change)
    );

    usrc_link_model usrc_link_model_inst (
        .clk_i(ref_clk), .srst_i(srst), .ready_i(tx_ready), .go_i(go),
        .stall_i(stall), .pid_i(pid), .nbytes_i(nbytes), .stop_byte_i(stop_byte),
        .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_stop_o(tx_stop), .busy_o(busy)
    );

    // Record strobes from the serialiser side
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (eop_req === 1'b1)
        begin
            eop_cnt   <= eop_cnt + 1;
            kind_seen <= eop_kind;
        end
        if (ser_sync === 1'b1)
            sync_cnt <= sync_cnt + 1;
        if (ser_valid === 1'b1)
        begin
            byte_cnt   <= byte_cnt + 1;
            last_data  <= ser_data;
            last_stuff <= stuff_en;
        end
        if (resume_k === 1'b1)
            rk_seen <= 1'b1;
        // Hang guard
        if (cyc == 3000)
        begin
            err_total++;
            give_verdict();
        end
    end

    // Compare one value against its expectation
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        begin
            compares++;
            if (seen !== exp)
            begin
                err_total++;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask : check

    // Send one packet and check its framing; eb < 0 skips the byte count
    task automatic run_pkt(input logic [1:0] m, input logic [7:0] p, input logic [3:0] n,
                           input logic [7:0] sb, input logic [1:0] ek, input int eb,
                           input int es);
        int e0;
        int b0;
        int s0;
        int w;
        begin
            e0 = eop_cnt;
            b0 = byte_cnt;
            s0 = sync_cnt;
            rk_seen = 1'b0;
            op_mode = m;
            pid = p;
            nbytes = n;
            stop_byte = sb;
            go = 1'b1;
            @(posedge ref_clk);
            #1 go = 1'b0;
            repeat (2) @(posedge ref_clk);
            w = 0;
            while (busy === 1'b1 && w < 60)
            begin
                @(posedge ref_clk);
                w++;
            end
            repeat (3) @(posedge ref_clk);
            #1;
            check(8'(eop_cnt - e0), 8'h01);
            check({6'h00, kind_seen}, {6'h00, ek});
            check(8'(sync_cnt - s0), 8'(es));
            if (eb >= 0)
                check(8'(byte_cnt - b0), 8'(eb));
        end
    endtask : run_pkt

    // Wait a bounded time for an ID change report
    task automatic await_id(input logic exp_level);
        int w;
        begin
            w = 0;
            while (id_change !== 1'b1 && w < int'(usrc_pkg::ID_REPORT_CYC))
            begin
                @(posedge ref_clk);
                #1;
                w++;
            end
            check({7'h00, id_change}, 8'h01);
            check({7'h00, id_level}, {7'h00, exp_level});
            @(posedge ref_clk);
            #1;
        end
    endtask : await_id

    // Print counts and verdict, then stop
    task automatic give_verdict();
        begin
            $display("compares=%0d err_total=%0d", compares, err_total);
            if (err_total == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask : give_verdict

    // Main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1 srst = 1'b0;
        @(posedge ref_clk);
        #1;
        check({7'h00, stuff_en}, 8'h01);
        check({7'h00, id_level}, 8'h01);
        check({7'h00, tx_ready}, 8'h01);
        check({7'h00, hs_term}, 8'h01);
        repeat (4) @(posedge ref_clk);
        #1;
        speed = 2'h1;
        term = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 check({7'h00, hs_term}, 8'h00);
        low_power_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check({7'h00, suspended}, 8'h01);
        check({7'h00, tx_ready}, 8'h00);
        // leave low power, then high speed again
        low_power_n = 1'b1;
        speed = 2'h0;
        term = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check({7'h00, suspended}, 8'h00);
        check({7'h00, hs_term}, 8'h01);
        pd_host = 1'b1;
        speed = 2'h1;
        term = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 check({7'h00, hs_term}, 8'h00);
        speed = 2'h0;
        term = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check({7'h00, hs_term}, 8'h01);
        pd_host = 1'b0;
        // Raw mode packets
        run_pkt(2'h3, 8'h2D, 4'h0, 8'hFE, 2'h2, 2, 0);
        check(last_data, 8'hFE);
        check({7'h00, last_stuff}, 8'h00);
        run_pkt(2'h3, 8'hC3, 4'h2, 8'h00, 2'h0, 3, 0);
        run_pkt(2'h3, 8'hA5, 4'h2, 8'h5A, 2'h3, -1, 0);
        run_pkt(2'h3, 8'h4B, 4'h1, 8'h77, 2'h1, -1, 0);
        // Framed modes, one with the link stalling
        run_pkt(2'h0, 8'hA5, 4'h2, 8'hFE, 2'h3, 3, 1);
        stall = 1'b1;
        run_pkt(2'h1, 8'hC3, 4'h3, 8'h00, 2'h1, 4, 1);
        stall = 1'b0;
        // resume signalling in chirp mode, host then peripheral
        pd_host = 1'b1;
        run_pkt(2'h2, 8'h00, 4'h3, 8'h00, 2'h1, 4, 0);
        check({7'h00, rk_seen}, 8'h01);
        check({7'h00, last_stuff}, 8'h00);
        pd_host = 1'b0;
        run_pkt(2'h2, 8'h00, 4'h1, 8'h00, 2'h0, 2, 0);
        check({7'h00, rk_seen}, 8'h01);
        op_mode = 2'h0;
        repeat (2) @(posedge ref_clk);
        #1 check({7'h00, hs_term}, 8'h01);
        // enable sensing with ID low, then release
        id_sense_en = 1'b1;
        id_pin = 1'b0;
        await_id(1'b0);
        id_pin = 1'b1;
        await_id(1'b1);
        give_verdict();
    end
endmodule : test_usrc_top

/* File: verification/usrc_link_model.sv */
// Behavioural link controller feeding the transmit port
// Assumes bytes are taken on edges where valid and ready are both high
`timescale 1ns/1ps
module usrc_link_model (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       ready_i,
    input  wire logic       go_i,
    input  wire logic       stall_i,
    input  wire logic [7:0] pid_i,
    input  wire logic [3:0] nbytes_i,
    input  wire logic [7:0] stop_byte_i,
    output logic [7:0]      tx_data_o,
    output logic            tx_valid_o,
    output logic            tx_stop_o,
    output logic            busy_o
);
    int i;  // Data byte index

    // Hold a byte until an edge with ready high takes it
    task automatic put_byte(input logic [7:0] b);
        logic taken;
        begin
            tx_data_o  = b;
            tx_valid_o = 1'b1;
            taken      = 1'b0;
            while (!taken)
            begin
                @(negedge clk_i);
                taken = ready_i;
                @(posedge clk_i);
            end
            #1;
        end
    endtask : put_byte

    // Packet sequencer: PID, data bytes, then a stop pulse
    initial
    begin
        tx_data_o  = 8'h00;
        tx_valid_o = 1'b0;
        tx_stop_o  = 1'b0;
        busy_o     = 1'b0;
        forever
        begin
            @(posedge clk_i);
            if (go_i && !srst_i)
            begin
                #1;
                busy_o = 1'b1;
                put_byte(pid_i);
                for (i = 0; i < int'(nbytes_i); i++)
                begin
                    // Optional idle gap, released line shows inverse
                    if (stall_i)
                    begin
                        tx_valid_o = 1'b0;
                        tx_data_o  = ~tx_data_o;
                        @(posedge clk_i);
                        #1;
                    end
                    put_byte(8'h10 + 8'(i));
                end
                tx_valid_o = 1'b0;
                tx_stop_o  = 1'b1;
                tx_data_o  = stop_byte_i;
                @(posedge clk_i);
                #1;
                tx_stop_o = 1'b0;
                tx_data_o = ~stop_byte_i;
                busy_o    = 1'b0;
            end
        end
    end
endmodule : usrc_link_model

/* File: verilog/usrc_id_report.sv */
// ID pin sensing with a stability filter and a change report pulse
// Assumes the ID pin is asynchronous to REF clock and pull-up gates sensing
`timescale 1ns/1ps
module usrc_id_report #(
    parameter int unsigned FILTER_CYC = usrc_pkg::ID_FILTER_CYC
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic id_pin_i,
    input  wire logic pullup_i,
    output logic      id_level_o,
    output logic      id_change_o
);

    localparam int FILT = FILTER_CYC;

    logic        id_s1_r;     // First synchroniser stage
    logic        id_s2_r;     // Second synchroniser stage
    logic [15:0] cnt_r;       // Stability counter
    logic        level_r;     // Reported ID level
    logic        change_r;    // Change report pulse

    // Two-stage synchroniser
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            id_s1_r <= 1'b1;
            id_s2_r <= 1'b1;
        end
        else
        begin
            id_s1_r <= id_pin_i;
            id_s2_r <= id_s1_r;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cnt_r    <= 16'h0000;
            level_r  <= 1'b1;
            change_r <= 1'b0;
        end
        else if (!pullup_i)
        begin
            // Sensing off, no report
            cnt_r    <= 16'h0000;
            change_r <= 1'b0;
        end
        else if (id_s2_r == level_r)
        begin
            // Glitch or no change
            cnt_r    <= 16'h0000;
            change_r <= 1'b0;
        end
        else if (cnt_r == 16'(FILT - 1))
        begin
            // Stable long enough: report
            cnt_r    <= 16'h0000;
            level_r  <= id_s2_r;
            change_r <= 1'b1;
        end
        else
        begin
            cnt_r    <= cnt_r + 16'h0001;
            change_r <= 1'b0;
        end
    end

    assign id_level_o  = level_r;
    assign id_change_o = change_r;

    // Report follows a full filter run
    AST_ID_REPORT: assert property (@(posedge clk_i) disable iff (srst_i)
        (pullup_i && id_s2_r != level_r && cnt_r == 16'(FILT - 1))
        |=> (id_change_o && id_level_o == $past(id_s2_r)))
        else $error("ID change not reported after filter");

    // No report without pull-up
    AST_ID_GATED: assert property (@(posedge clk_i) disable iff (srst_i)
        !pullup_i |=> !id_change_o)
        else $error("ID reported while pull-up off");

    COV_ID_CHANGE: cover property (@(posedge clk_i) disable iff (srst_i) id_change_o);

endmodule : usrc_id_report

/* File: verilog/usrc_top.sv */
// Transceiver-side transmit framing, resume EOP and ID reporting control
// Assumes the link drives bytes and stop on the REF clock; serialiser follows
//
// Overview of operation
// - Transceiver appends EOP when host resume ends
// - Raw mode drops SYNC, keeps EOP and stuffing
// - Raw stop with FEh disables EOP stuffing
// - Raw stop with 00h sends no EOP
// - Raw PID A5h gives long EOP
// - ID change reported within report time
`timescale 1ns/1ps
module usrc_top #(
    parameter int unsigned ID_FILTER = usrc_pkg::ID_FILTER_CYC
) (
    input  wire logic       REF_CLK_I,
    input  wire logic       SRST_I,
    input  wire logic [1:0] OPERATING_MODE_I,
    input  wire logic [1:0] SPEED_SELECT_I,
    input  wire logic       TERMINATION_SELECT_I,
    input  wire logic       LOW_POWER_N_I,
    input  wire logic       PLUS_LINE_PULLDOWN_I,
    input  wire logic       MINUS_LINE_PULLDOWN_I,
    input  wire logic       ID_SENSE_PULLUP_I,
    input  wire logic       ID_PIN_I,
    input  wire logic [7:0] TX_DATA_I,
    input  wire logic       TX_VALID_I,
    input  wire logic       TX_STOP_I,
    output logic            TX_READY_O,
    output logic [7:0]      SER_DATA_O,
    output logic            SER_VALID_O,
    output logic            SER_STUFF_EN_O,
    output logic            SER_SYNC_O,
    output logic            EOP_REQ_O,
    output logic [1:0]      EOP_KIND_O,
    output logic            RESUME_K_O,
    output logic            SUSPENDED_O,
    output logic            HS_TERM_O,
    output logic            ID_LEVEL_O,
    output logic            ID_CHANGE_O
);

    usrc_pkg::usrc_state_t state_r;     // Sequencer state
    logic [7:0]            hold_r;      // First byte held during SYNC
    logic [1:0]            mode_r;      // Mode latched per packet
    logic                  sof_r;       // Packet PID was SOF
    logic [7:0]            sdata_r;     // Serialiser data
    logic                  svalid_r;    // Serialiser byte strobe
    logic                  sstuff_r;    // Bit stuffing enable
    logic                  ssync_r;     // Auto SYNC strobe
    logic                  eop_req_r;   // EOP request strobe
    logic [1:0]            eop_kind_r;  // EOP kind
    logic                  resume_r;    // Driving chirp or resume K
    logic                  susp_r;      // Low-power indication
    logic                  hsterm_r;    // High-speed termination on
    logic                  tx_take;     // Byte accepted this cycle
    logic                  stop_take;   // Stop accepted this cycle
    logic                  is_host;     // Both pull-downs set

    // Decode whether a mode frames packets automatically
    function automatic logic auto_frame(input logic [1:0] m);
        auto_frame = (m == usrc_pkg::MODE_NORMAL) || (m == usrc_pkg::MODE_NODRIVE);
    endfunction : auto_frame

    // Decode the end kind for a framed packet
    function automatic logic [1:0] framed_kind(input logic sof);
        framed_kind = sof ? usrc_pkg::EOP_LONG : usrc_pkg::EOP_NORMAL;
    endfunction : framed_kind

    // Handshake decode
    assign is_host    = PLUS_LINE_PULLDOWN_I & MINUS_LINE_PULLDOWN_I;
    assign TX_READY_O = LOW_POWER_N_I
                        && (state_r == usrc_pkg::ST_IDLE || state_r == usrc_pkg::ST_DATA);
    assign tx_take    = TX_VALID_I && TX_READY_O && !TX_STOP_I;
    assign stop_take  = TX_STOP_I && LOW_POWER_N_I && (state_r == usrc_pkg::ST_DATA);

    // Sequencer state
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I || !LOW_POWER_N_I)
        begin
            state_r <= usrc_pkg::ST_IDLE;
        end
        else
        begin
            case (state_r)
                usrc_pkg::ST_IDLE:
                begin
                    if (tx_take && auto_frame(OPERATING_MODE_I))
                        state_r <= usrc_pkg::ST_SYNC;
                    else if (tx_take)
                        state_r <= usrc_pkg::ST_DATA;
                end
                usrc_pkg::ST_SYNC:
                begin
                    state_r <= usrc_pkg::ST_DATA;
                end
                usrc_pkg::ST_DATA:
                begin
                    if (stop_take)
                        state_r <= usrc_pkg::ST_IDLE;
                end
                default:
                begin
                    state_r <= usrc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Per-packet mode, SOF flag and held byte
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            hold_r <= 8'h00;
            mode_r <= usrc_pkg::MODE_NORMAL;
            sof_r  <= 1'b0;
        end
        else if (tx_take && state_r == usrc_pkg::ST_IDLE)
        begin
            hold_r <= TX_DATA_I;
            mode_r <= OPERATING_MODE_I;
            sof_r  <= (TX_DATA_I == usrc_pkg::PID_SOF);
        end
    end

    // Serialiser byte path
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            sdata_r  <= 8'h00;
            svalid_r <= 1'b0;
            sstuff_r <= 1'b1;
            ssync_r  <= 1'b0;
        end
        else
        begin
            svalid_r <= 1'b0;
            ssync_r  <= 1'b0;
            if (state_r == usrc_pkg::ST_IDLE && tx_take)
            begin
                if (auto_frame(OPERATING_MODE_I))
                begin
                    // Framed: SYNC first, byte next cycle
                    ssync_r <= 1'b1;
                end
                else
                begin
                    // raw and chirp send byte at once, stuffed in raw only
                    sdata_r  <= TX_DATA_I;
                    svalid_r <= 1'b1;
                    sstuff_r <= (OPERATING_MODE_I == usrc_pkg::MODE_RAW);
                end
            end
            else if (state_r == usrc_pkg::ST_SYNC)
            begin
                // Held first byte after SYNC
                sdata_r  <= hold_r;
                svalid_r <= 1'b1;
                sstuff_r <= 1'b1;
            end
            else if (tx_take)
            begin
                // Chirp and resume bytes are never stuffed
                sdata_r  <= TX_DATA_I;
                svalid_r <= 1'b1;
                sstuff_r <= (mode_r != usrc_pkg::MODE_CHIRP);
            end
            else if (stop_take && mode_r == usrc_pkg::MODE_RAW
                     && TX_DATA_I == usrc_pkg::BYTE_EOP_NOSTUFF)
            begin
                sdata_r  <= TX_DATA_I;
                svalid_r <= 1'b1;
                sstuff_r <= 1'b0;
            end
        end
    end

    // End-of-packet request
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            eop_req_r  <= 1'b0;
            eop_kind_r <= usrc_pkg::EOP_NONE;
        end
        else
        begin
            eop_req_r <= stop_take;
            if (stop_take)
            begin
                case (mode_r)
                    usrc_pkg::MODE_RAW:
                    begin
                        if (TX_DATA_I == usrc_pkg::BYTE_EOP_NOSTUFF)
                            eop_kind_r <= usrc_pkg::EOP_NOSTUFF;
                        else if (TX_DATA_I == usrc_pkg::BYTE_EOP_NONE)
                            eop_kind_r <= usrc_pkg::EOP_NONE;
                        else
                            eop_kind_r <= framed_kind(sof_r);
                    end
                    usrc_pkg::MODE_CHIRP:
                    begin
                        eop_kind_r <= is_host ? usrc_pkg::EOP_NORMAL : usrc_pkg::EOP_NONE;
                    end
                    default:
                    begin
                        eop_kind_r <= framed_kind(sof_r);
                    end
                endcase
            end
        end
    end

    // Resume or chirp K drive level
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I || !LOW_POWER_N_I)
            resume_r <= 1'b0;
        else if (state_r == usrc_pkg::ST_IDLE && tx_take)
            resume_r <= (OPERATING_MODE_I == usrc_pkg::MODE_CHIRP);
        else if (stop_take)
            resume_r <= 1'b0;
    end

    // Power and termination status
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            susp_r   <= 1'b0;
            hsterm_r <= 1'b0;
        end
        else
        begin
            susp_r   <= !LOW_POWER_N_I;
            hsterm_r <= (SPEED_SELECT_I == usrc_pkg::SPEED_HIGH) && !TERMINATION_SELECT_I;
        end
    end

    usrc_id_report #(
        .FILTER_CYC (ID_FILTER)
    ) usrc_id_report_inst (
        .clk_i       (REF_CLK_I),
        .srst_i      (SRST_I),
        .id_pin_i    (ID_PIN_I),
        .pullup_i    (ID_SENSE_PULLUP_I),
        .id_level_o  (ID_LEVEL_O),
        .id_change_o (ID_CHANGE_O)
    );

    // Output connections
    assign SER_DATA_O     = sdata_r;
    assign SER_VALID_O    = svalid_r;
    assign SER_STUFF_EN_O = sstuff_r;
    assign SER_SYNC_O     = ssync_r;
    assign EOP_REQ_O      = eop_req_r;
    assign EOP_KIND_O     = eop_kind_r;
    assign RESUME_K_O     = resume_r;
    assign SUSPENDED_O    = susp_r;
    assign HS_TERM_O      = hsterm_r;

    AST_RAW_NO_SYNC: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (state_r == usrc_pkg::ST_IDLE && tx_take && OPERATING_MODE_I == usrc_pkg::MODE_RAW)
        |=> (!SER_SYNC_O && SER_VALID_O && SER_STUFF_EN_O && SER_DATA_O == $past(TX_DATA_I)))
        else $error("Raw mode produced SYNC or lost first byte");

    AST_AUTO_SYNC: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (state_r == usrc_pkg::ST_IDLE && tx_take && OPERATING_MODE_I == usrc_pkg::MODE_NORMAL)
        |=> SER_SYNC_O && !SER_VALID_O ##1 SER_VALID_O && SER_DATA_O == $past(TX_DATA_I, 2))
        else $error("Normal mode SYNC sequence wrong");

    AST_RAW_STUFF: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (state_r == usrc_pkg::ST_DATA && tx_take && mode_r == usrc_pkg::MODE_RAW)
        |=> SER_VALID_O && SER_STUFF_EN_O)
        else $error("Raw mode data not stuffed");

    AST_FE_NOSTUFF: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (stop_take && mode_r == usrc_pkg::MODE_RAW
         && TX_DATA_I == usrc_pkg::BYTE_EOP_NOSTUFF)
        |=> EOP_REQ_O && EOP_KIND_O == usrc_pkg::EOP_NOSTUFF && SER_VALID_O && !SER_STUFF_EN_O)
        else $error("FEh stop did not disable EOP stuffing");

    AST_00_NO_EOP: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (stop_take && mode_r == usrc_pkg::MODE_RAW && TX_DATA_I == usrc_pkg::BYTE_EOP_NONE)
        |=> EOP_KIND_O == usrc_pkg::EOP_NONE && !SER_VALID_O)
        else $error("00h stop produced an EOP");

    AST_SOF_LONG: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (stop_take && mode_r == usrc_pkg::MODE_RAW && sof_r
         && TX_DATA_I != usrc_pkg::BYTE_EOP_NONE && TX_DATA_I != usrc_pkg::BYTE_EOP_NOSTUFF)
        |=> EOP_REQ_O && EOP_KIND_O == usrc_pkg::EOP_LONG)
        else $error("SOF packet did not get long EOP");

    AST_RESUME_EOP: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (stop_take && mode_r == usrc_pkg::MODE_CHIRP && is_host && RESUME_K_O)
        |=> EOP_REQ_O && EOP_KIND_O == usrc_pkg::EOP_NORMAL && !RESUME_K_O)
        else $error("Host resume end lacked EOP");

    // EOP only at end of packet
    AST_EOP_ENDS: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        EOP_REQ_O |-> state_r == usrc_pkg::ST_IDLE && $past(state_r) == usrc_pkg::ST_DATA)
        else $error("EOP outside packet end");

    COV_RAW_FE: cover property (@(posedge REF_CLK_I) disable iff (SRST_I)
        EOP_REQ_O && EOP_KIND_O == usrc_pkg::EOP_NOSTUFF);
    COV_RAW_SOF: cover property (@(posedge REF_CLK_I) disable iff (SRST_I)
        EOP_REQ_O && EOP_KIND_O == usrc_pkg::EOP_LONG);
    COV_RESUME: cover property (@(posedge REF_CLK_I) disable iff (SRST_I)
        RESUME_K_O ##[1:50] EOP_REQ_O);
    COV_FRAMED: cover property (@(posedge REF_CLK_I) disable iff (SRST_I) SER_SYNC_O);

endmodule : usrc_top
